// ### common/bsasp_map.vh
// timing and field constants for the byte-select async sram port controller
`ifndef BSASP_MAP_VH
`define BSASP_MAP_VH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define BSASP_ADDR_W        18
`define BSASP_DATA_W        32
`define BSASP_LANES         4

// ----------------------------------------------------------------------------
// timing in ns, fastest grade
// ----------------------------------------------------------------------------
`define BSASP_CLK_NS                        5
`define BSASP_ADDRESS_SETUP_TO_WRITE_START  2
`define BSASP_ADDRESS_SETUP_TO_WRITE_END    18
`define BSASP_ADDRESS_HOLD_AFTER_WRITE_END  2
`define BSASP_DATA_SETUP_TO_WRITE_END       13
`define BSASP_DATA_HOLD_AFTER_WRITE_END     2
`define BSASP_SELECT_LOW_TO_WRITE_END       18
`define BSASP_WRITE_PULSE_WIDTH             15
`define BSASP_ADDRESS_ACCESS_TIME           20
`define BSASP_SELECT_ACCESS_TIME            20
`define BSASP_SELECT_HIGH_TO_FLOAT          20

// ----------------------------------------------------------------------------
// cycle counts; least times round up
// ----------------------------------------------------------------------------
`define BSASP_CYC_UP(ns) (((ns) + `BSASP_CLK_NS - 1) / `BSASP_CLK_NS)
`define BSASP_SA_CYC  `BSASP_CYC_UP(`BSASP_ADDRESS_SETUP_TO_WRITE_START)
`define BSASP_WE_CYC  `BSASP_CYC_UP(`BSASP_WRITE_PULSE_WIDTH)
`define BSASP_AW_CYC  `BSASP_CYC_UP(`BSASP_ADDRESS_SETUP_TO_WRITE_END)
`define BSASP_HD_CYC  `BSASP_CYC_UP(`BSASP_DATA_HOLD_AFTER_WRITE_END)
// read samples after access time plus the three-flop input path
`define BSASP_RD_CYC  (`BSASP_CYC_UP(`BSASP_ADDRESS_ACCESS_TIME) + 3)
`define BSASP_HZ_CYC  `BSASP_CYC_UP(`BSASP_SELECT_HIGH_TO_FLOAT)

`endif

// ### logic/bsasp_ctrl.v
// host-side controller driving a 256k x 32 byte-select asynchronous sram
// Function
// RULE1: memory holds 256K words of 32 bits, 18-bit address, shared data bus
// RULE2: four selects gate byte lanes, two write enables cover half-words
// RULE3: a write happens only while select and its write enable are both low
// RULE4: a write ends when select or write enable rises first
// RULE5: data stable 13 ns before write end and 2 ns after it
// RULE6: address stable at least 18 ns before the write ends
// RULE7: address held at least 2 ns after the write ends
// RULE8: address set up at least 2 ns before the write begins
// RULE9: select low 18 ns before write end, write pulse at least 15 ns
// RULE10: read data valid within 20 ns of stable address
// RULE11: read data valid within 20 ns of select going low
// RULE12: old read data stays valid 5 ns after address change
// RULE13: write enables stay high throughout a read
// RULE14: deselected device powers down within 20 ns, wakes at once
// RULE15: select and write enable rising together keeps outputs floating
// RULE16: device floats outputs faster than it starts driving them
`include "bsasp_map.vh"

module bsasp_ctrl (
  // clock and reset
  input  wire                        mclk,
  input  wire                        reset,
  // user request
  input  wire                        req_valid,
  input  wire                        req_write,
  input  wire [`BSASP_ADDR_W-1:0]    req_addr,
  input  wire [`BSASP_DATA_W-1:0]    req_wdata,
  input  wire [`BSASP_LANES-1:0]     req_lanes,
  output reg                         req_ready_q,
  // user answer
  output reg                         rsp_valid_q,
  output reg  [`BSASP_DATA_W-1:0]    rsp_rdata_q,
  // memory pins
  output reg  [`BSASP_ADDR_W-1:0]    address_bus_q,
  output reg  [`BSASP_LANES-1:0]     sel_n_q,
  output reg  [1:0]                  we_n_q,
  input  wire [`BSASP_DATA_W-1:0]    data_in,
  output reg  [`BSASP_DATA_W-1:0]    data_out_q,
  output reg                         data_oe_q
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WSET  = 3'h1;
  localparam [2:0] ST_WPUL  = 3'h2;
  localparam [2:0] ST_WHOLD = 3'h3;
  localparam [2:0] ST_RACC  = 3'h4;
  localparam [2:0] ST_FLOAT = 3'h5;

  // cycle counts worked out as integers, then cut to the counter width on purpose
  localparam integer SA_CYC_I = `BSASP_SA_CYC;
  localparam integer WE_CYC_I = `BSASP_WE_CYC;
  localparam integer AW_CYC_I = `BSASP_AW_CYC;
  localparam integer HD_CYC_I = `BSASP_HD_CYC;
  localparam integer RD_CYC_I = `BSASP_RD_CYC;
  localparam integer HZ_CYC_I = `BSASP_HZ_CYC;
  // pulse covers both write-pulse and setup-to-end minima
  localparam integer WP_CYC_I = (AW_CYC_I > WE_CYC_I) ? AW_CYC_I : WE_CYC_I;

  // counter is four bits: a slower grade needing over 15 cycles must widen it
  localparam [3:0] SA_CYC = SA_CYC_I[3:0];
  localparam [3:0] WP_CYC = WP_CYC_I[3:0];
  localparam [3:0] HD_CYC = HD_CYC_I[3:0];
  localparam [3:0] RD_CYC = RD_CYC_I[3:0];
  localparam [3:0] HZ_CYC = HZ_CYC_I[3:0];

  // --------------------------------------------------------------------------
  // half-word write enables from lane mask
  // --------------------------------------------------------------------------
  function [1:0] lanes_to_we;
    input [3:0] lanes;
    begin
      lanes_to_we = {|lanes[3:2], |lanes[1:0]}; // RULE2
    end
  endfunction

  reg  [2:0]                 state_q;
  reg  [3:0]                 cnt_q;
  reg  [`BSASP_LANES-1:0]    lanes_q;
  reg  [`BSASP_DATA_W-1:0]   din_s1_q;
  reg  [`BSASP_DATA_W-1:0]   din_s2_q;
  reg  [`BSASP_DATA_W-1:0]   din_s3_q;

  // --------------------------------------------------------------------------
  // read data synchroniser; sampled only when second and third stages agree
  // --------------------------------------------------------------------------
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      din_s1_q <= 32'h0;
      din_s2_q <= 32'h0;
      din_s3_q <= 32'h0;
    end
    else
    begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
    end
  end

  // --------------------------------------------------------------------------
  // cycle sequencer
  // --------------------------------------------------------------------------
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q       <= ST_IDLE;
      cnt_q         <= 4'h0;
      lanes_q       <= 4'h0;
      req_ready_q   <= 1'b0;
      rsp_valid_q   <= 1'b0;
      rsp_rdata_q   <= 32'h0;
      address_bus_q <= 18'h0;
      sel_n_q       <= 4'hf;
      we_n_q        <= 2'h3;
      data_out_q    <= 32'h0;
      data_oe_q     <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          req_ready_q <= 1'b1;
          if (req_valid && req_ready_q)
          begin
            req_ready_q   <= 1'b0;
            address_bus_q <= req_addr; // RULE1
            lanes_q       <= req_lanes;
            if (req_write)
            begin
              // address and data settle before any strobe falls
              data_out_q <= req_wdata;
              data_oe_q  <= 1'b1;
              cnt_q      <= SA_CYC;
              state_q    <= ST_WSET; // RULE8
            end
            else
            begin
              sel_n_q <= ~req_lanes; // RULE2
              we_n_q  <= 2'h3; // RULE13
              cnt_q   <= RD_CYC;
              state_q <= ST_RACC;
            end
          end
        end
        ST_WSET:
        begin
          if (cnt_q > 4'h1)
            cnt_q <= cnt_q - 4'h1;
          else
          begin
            // select and write enable fall together: overlap starts here
            sel_n_q <= ~lanes_q; // RULE3
            we_n_q  <= ~lanes_to_we(lanes_q); // RULE2
            cnt_q   <= WP_CYC;
            state_q <= ST_WPUL;
          end
        end
        ST_WPUL:
        begin
          if (cnt_q > 4'h1)
            cnt_q <= cnt_q - 4'h1; // RULE9 RULE6 RULE5
          else
          begin
            // write enable rises first and ends the write
            we_n_q  <= 2'h3; // RULE4
            cnt_q   <= HD_CYC;
            state_q <= ST_WHOLD;
          end
        end
        ST_WHOLD:
        begin
          if (cnt_q > 4'h1)
            cnt_q <= cnt_q - 4'h1; // RULE7 RULE5
          else
          begin
            sel_n_q     <= 4'hf;
            data_oe_q   <= 1'b0;
            req_ready_q <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        ST_RACC:
        begin
          if (cnt_q > 4'h1)
            cnt_q <= cnt_q - 4'h1; // RULE10 RULE11
          else if (din_s2_q == din_s3_q)
          begin
            rsp_rdata_q <= din_s3_q;
            rsp_valid_q <= 1'b1;
            sel_n_q     <= 4'hf; // RULE14
            cnt_q       <= HZ_CYC;
            state_q     <= ST_FLOAT;
          end
        end
        ST_FLOAT:
        begin
          // let the memory release the bus before we may drive it
          if (cnt_q > 4'h1)
            cnt_q <= cnt_q - 4'h1; // RULE16
          else
          begin
            req_ready_q <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### verification/bsasp_chk.sv
// pin-level assertions for the sram controller
module bsasp_chk (
  input wire        mclk,
  input wire        reset,
  input wire [3:0]  sel_n_q,
  input wire [1:0]  we_n_q,
  input wire [17:0] address_bus_q,
  input wire [31:0] data_out_q,
  input wire        data_oe_q,
  input wire        rsp_valid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire wr = we_n_q != 2'h3;
  chk_lane_cover: assert property ((we_n_q[0] || sel_n_q[1:0] != 2'h3) &&
    (we_n_q[1] || sel_n_q[3:2] != 2'h3)) else $error("enable without select");
  chk_write_drive: assert property (wr |-> data_oe_q) else $error("data not driven");
  chk_write_stable: assert property (wr ##1 wr |->
    $stable(address_bus_q) && $stable(data_out_q)) else $error("moved in write");
  chk_setup_start: assert property (!wr ##1 wr |-> $stable(address_bus_q))
    else $error("address late");
  chk_pulse_width: assert property (!wr ##1 wr |=> wr [*2]) else $error("pulse short");
  chk_end_hold: assert property (wr ##1 !wr |-> $stable(address_bus_q) &&
    $stable(data_out_q) && data_oe_q) else $error("no hold");
  chk_read_no_we: assert property (sel_n_q != 4'hf && !data_oe_q |-> !wr)
    else $error("enable in read");
  chk_access_wait: assert property ($fell(&sel_n_q) && !data_oe_q |-> !rsp_valid_q [*4])
    else $error("read too early");
  chk_float_gap: assert property (rsp_valid_q |-> (&sel_n_q && !data_oe_q) [*4])
    else $error("no float gap");
  cover property (wr ##1 !wr);
  cover property (rsp_valid_q);
  cover property (!wr ##1 we_n_q == 2'h2);
endmodule

// ### verification/bsasp_sram_model.sv
// behavioural model of the 256k x 32 byte-select sram
module bsasp_sram_model (
  input  wire [17:0] address_bus,
  input  wire [3:0]  sel_n,
  input  wire [1:0]  we_n,
  input  wire [31:0] data_out,
  input  wire        data_oe,
  output wire [31:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [int];
  logic [31:0] q = 32'h0;
  int          ver = 0;
  wire  [3:0]  hw = {we_n[1], we_n[1], we_n[0], we_n[0]};
  wire  [3:0]  rd = ~sel_n & hw;
  wire  [3:0]  wr = ~sel_n & ~hw;
  wire  [31:0] m = {{8{rd[3]}}, {8{rd[2]}}, {8{rd[1]}}, {8{rd[0]}}};
  // lanes not driving show the inverted last word so stale data never passes
  assign data_in = data_oe ? data_out : q ^ ~m;
  // storing follows the overlap, so whichever strobe rises first ends it
  always @(address_bus or wr or data_in)
  begin
    if (wr != 4'h0 && !mem.exists(address_bus)) mem[address_bus] = 32'h0;
    for (int i = 0; i < 4; i++)
      if (wr[i]) mem[address_bus][8*i+:8] = data_in[8*i+:8];
  end
  // any change scrambles the output until a full access time has passed
  always @(address_bus or rd)
  begin
    ver++;
    q = ~q;
    fork
      begin
        automatic int k = ver;
        #20 if (k == ver) q = mem.exists(address_bus) ? mem[address_bus] : 32'h0;
      end
    join_none
  end
endmodule

// ### verification/byte_select_async_sram_port_tb.sv
// self-checking bench for the byte-select sram controller
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin failures++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module byte_select_async_sram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, reset = 1, req_valid = 0, req_write = 0;
  logic [17:0] req_addr = 18'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0]  req_lanes = 4'h0;
  wire         req_ready_q, rsp_valid_q, data_oe_q;
  wire  [31:0] rsp_rdata_q, data_in, data_out_q;
  wire  [17:0] address_bus_q;
  wire  [3:0]  sel_n_q;
  wire  [1:0]  we_n_q;
  int          failures = 0, checks = 0, cyc = 0;
  logic [31:0] shadow [int];
  bsasp_ctrl bsasp_ctrl_inst (.mclk(mclk), .reset(reset), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lanes(req_lanes), .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q), .address_bus_q(address_bus_q), .sel_n_q(sel_n_q),
    .we_n_q(we_n_q), .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q));
  bsasp_sram_model bsasp_sram_model_inst (.address_bus(address_bus_q), .sel_n(sel_n_q),
    .we_n(we_n_q), .data_out(data_out_q), .data_oe(data_oe_q), .data_in(data_in));
  always #2.5 mclk = ~mclk;
  function [31:0] msk(input [3:0] l);
    msk = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  function [31:0] peek(input [17:0] a);
    peek = shadow.exists(a) ? shadow[a] : 32'h0;
  endfunction
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // requests raised while ready is low simply wait to be taken
  task issue(input w, input [17:0] a, input [31:0] d, input [3:0] l);
    @(posedge mclk);
    #1 {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, l};
    @(posedge mclk);
    while (req_ready_q !== 1'b1) @(posedge mclk);
    #1 req_valid = 0;
    if (w)
      shadow[a] = (peek(a) & ~msk(l)) | (d & msk(l));
    else
    begin
      @(posedge mclk);
      while (rsp_valid_q !== 1'b1) @(posedge mclk);
      #1 `CHK("rdata", peek(a) & msk(l), rsp_rdata_q & msk(l))
    end
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      stop_test;
    end
  end
  initial
  begin
    void'($urandom(32'h0eb71b50));
    repeat (10) @(posedge mclk);
    #1 reset = 0;
    issue(1, 18'h3ffff, 32'h89abcdef, 4'hf);
    issue(0, 18'h3ffff, 32'h0, 4'hf);
    for (int i = 0; i < 16; i++)
    begin
      issue(1, 18'h1, $urandom, 4'(i));
      issue(0, 18'h1, 32'h0, 4'hf);
    end
    issue(1, 18'h20, 32'h0, 4'hf);
    reset = 1;
    #1 `CHK("idle pins", 7'h7e, {sel_n_q, we_n_q, data_oe_q})
    @(posedge mclk);
    #1 reset = 0;
    repeat (60) issue(1'($urandom), 18'($urandom_range(7)), $urandom, 4'($urandom));
    stop_test;
  end
endmodule
bind bsasp_ctrl bsasp_chk bsasp_chk_inst (.*);
